// File: rtl/wake_frame_detector.sv
/*
 Wake frame detector with Wishbone register slave and interrupt.
 Assumes a byte stream with a per-byte strobe, synchronous to i_clk_sys.
*/
`timescale 1ns/1ps
module wake_frame_detector
    import wake_pkg::*;
(
    // Clock and reset
    input  wire logic        i_clk_sys,
    input  wire logic        i_srst,
    // Receive byte stream
    input  wire rx_byte_type i_rx,
    // Wishbone slave
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [11:0] i_wb_adr,
    input  wire logic [3:0]  i_wb_sel,
    input  wire logic [31:0] i_wb_dat,
    output logic             o_wb_ack,
    output logic [31:0]      o_wb_dat,
    // Wake outputs
    output logic             o_irq,
    output logic             o_wake_pin
);
    logic [CFG_W-1:0]  cfg_q;
    logic [STS_W-1:0]  sts_q;
    logic [STS_W-1:0]  sts_d;
    logic [STS_W-1:0]  mask_q;
    logic [47:0]       node_q;
    logic [47:0]       pw_q;
    logic [511:0]      pat_q;
    logic [31:0]       rd_d;
    logic              dv_q;
    logic              err_q;
    logic [6:0]        pos_q;
    logic              ucast_q;
    logic              bcast_q;
    logic              sa_ok_q;
    scan_state_type    st_q;
    logic [2:0]        ff_q;
    logic [2:0]        idx_q;
    logic [3:0]        rep_q;
    logic              fr_end;
    logic              byte_stb;
    logic [7:0]        b;
    logic              crc_ok;
    logic              pat_hit;
    logic              addressed;
    logic              magic_ev;
    logic              pat_ev;
    logic              rej_ev;
    logic              wr_acc;
    logic [9:0]        idx_w;
    logic [STS_W-1:0]  sts_clr;
    logic [31:0]       wr_mrg;

    function automatic logic [7:0] pick(input logic [47:0] v,
                                        input logic [2:0]  i);
        return v[{i, 3'b000} +: 8];
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] o,
                                          input logic [31:0] n,
                                          input logic [3:0]  s);
        logic [31:0] r;
        for (int k = 0; k < 4; k++) begin
            r[k*8 +: 8] = s[k] ? n[k*8 +: 8] : o[k*8 +: 8];
        end
        return r;
    endfunction

    // Byte strobe abstracts the line rate
    assign byte_stb = i_rx.dv && i_rx.stb;
    assign b        = i_rx.data;
    // Per-frame state clears while idle, so byte 0 may share the dv edge
    assign fr_end   = dv_q && !i_rx.dv;

    wake_crc_check u_crc (
        .i_clk_sys (i_clk_sys),
        .i_srst    (i_srst),
        .i_start   (!i_rx.dv),
        .i_stb     (byte_stb),
        .i_data    (b),
        .o_good    (crc_ok)
    );

    wake_pattern_match u_pat (
        .i_clk_sys (i_clk_sys),
        .i_srst    (i_srst),
        .i_start   (!i_rx.dv),
        .i_stb     (byte_stb),
        .i_pos     (pos_q),
        .i_data    (b),
        .i_pattern (pat_q),
        .o_match   (pat_hit)
    );

    // Frame tracking
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            dv_q  <= 1'b0;
            err_q <= 1'b0;
            pos_q <= 7'h00;
        end else begin
            dv_q <= i_rx.dv;
            if (!i_rx.dv) begin
                err_q <= 1'b0;
                pos_q <= 7'h00;
            end else begin
                if (i_rx.er) begin
                    err_q <= 1'b1;
                end
                if (byte_stb && pos_q != POS_MAX) begin
                    pos_q <= pos_q + 7'h01;
                end
            end
        end
    end

    // Destination and source qualification
    always_ff @(posedge i_clk_sys) begin
        // Still valid in the fr_end cycle; cleared one edge later
        if (i_srst || !i_rx.dv) begin
            ucast_q <= 1'b1;
            bcast_q <= 1'b1;
            sa_ok_q <= 1'b0;
        end else if (byte_stb) begin
            if (pos_q < DA_LEN) begin
                if (b != pick(node_q, pos_q[2:0])) begin
                    ucast_q <= 1'b0;
                end
                if (b != ALL_ONES) begin
                    bcast_q <= 1'b0;
                end
            end
            // Group bit set means no valid source
            if (pos_q == DA_LEN) begin
                sa_ok_q <= !b[0];
            end
        end
    end

    // Continuous search from the first payload byte
    always_ff @(posedge i_clk_sys) begin
        if (i_srst || !i_rx.dv) begin
            st_q  <= ST_SYNC;
            ff_q  <= 3'h0;
            idx_q <= 3'h0;
            rep_q <= 4'h0;
        end else if (byte_stb && pos_q >= PAY_POS) begin
            case (st_q)
                ST_SYNC: begin
                    if (b == ALL_ONES) begin
                        if (ff_q != SYNC_LEN) begin
                            ff_q <= ff_q + 3'h1;
                        end
                    end else if (ff_q == SYNC_LEN &&
                                 b == pick(node_q, 3'h0)) begin
                        st_q  <= ST_REP;
                        idx_q <= 3'h1;
                        rep_q <= 4'h0;
                    end else begin
                        ff_q <= 3'h0;
                    end
                end
                ST_REP: begin
                    if (b == pick(node_q, idx_q)) begin
                        if (idx_q == ADDR_END) begin
                            idx_q <= 3'h0;
                            if (rep_q == REP_END) begin
                                st_q <= cfg_q[CFG_PW_EN] ? ST_PW
                                                         : ST_HIT;
                            end else begin
                                rep_q <= rep_q + 4'h1;
                            end
                        end else begin
                            idx_q <= idx_q + 3'h1;
                        end
                    end else begin
                        st_q <= ST_SYNC;
                        ff_q <= (b == ALL_ONES) ? 3'h1 : 3'h0;
                    end
                end
                ST_PW: begin
                    if (b == pick(pw_q, idx_q)) begin
                        if (idx_q == ADDR_END) begin
                            st_q <= ST_HIT;
                        end else begin
                            idx_q <= idx_q + 3'h1;
                        end
                    end else begin
                        st_q <= ST_SYNC;
                        ff_q <= (b == ALL_ONES) ? 3'h1 : 3'h0;
                    end
                end
                ST_HIT: begin
                    st_q <= ST_HIT;
                end
                default: begin
                    st_q <= ST_SYNC;
                end
            endcase
        end
    end

    // Frame-end decision; CRC and pattern are final by now
    assign addressed = ((ucast_q && cfg_q[CFG_UCAST_EN]) ||
                        (bcast_q && cfg_q[CFG_BCAST_EN])) &&
                       sa_ok_q && pos_q > PAY_POS;
    assign magic_ev = fr_end && cfg_q[CFG_MAGIC_EN] && st_q == ST_HIT &&
                      addressed && crc_ok && !err_q;
    assign pat_ev   = fr_end && cfg_q[CFG_PAT_EN] && pat_hit &&
                      addressed && crc_ok && !err_q;
    assign rej_ev   = fr_end && addressed && (!crc_ok || err_q) &&
                      ((cfg_q[CFG_MAGIC_EN] && st_q == ST_HIT) ||
                       (cfg_q[CFG_PAT_EN] && pat_hit));

    // Bus access decode
    // Write lands on the edge at which the master sees ack
    assign wr_acc = i_wb_cyc && i_wb_stb && i_wb_we && o_wb_ack;
    assign wr_mrg = merge(rd_d, i_wb_dat, i_wb_sel);
    assign idx_w  = i_wb_adr[11:2];
    assign sts_clr = (wr_acc && idx_w == WAKE_STATUS_REG_IDX && i_wb_sel[0])
                     ? i_wb_dat[STS_W-1:0] : '0;

    // Sticky status, set wins over write-one clear
    always_comb begin
        sts_d = sts_q & ~sts_clr;
        sts_d[STS_MAGIC] = sts_d[STS_MAGIC] | magic_ev;
        sts_d[STS_PAT]   = sts_d[STS_PAT] | pat_ev;
        sts_d[STS_CRC]   = sts_d[STS_CRC] | rej_ev;
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            sts_q <= '0;
        end else begin
            sts_q <= sts_d;
        end
    end

    // Writable registers
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            cfg_q  <= CFG_RST;
            mask_q <= MASK_RST;
            node_q <= '0;
            pw_q   <= '0;
            pat_q  <= '0;
        end else if (wr_acc) begin
            case (idx_w)
                WAKE_CONFIG_REG_IDX: cfg_q <= wr_mrg[CFG_W-1:0];
                WAKE_MASK_IDX:       mask_q <= wr_mrg[STS_W-1:0];
                NODE_ADDR_LO_IDX:    node_q[31:0] <= wr_mrg;
                NODE_ADDR_HI_IDX:    node_q[47:32] <= wr_mrg[15:0];
                PASSWORD_LO_IDX:     pw_q[31:0] <= wr_mrg;
                PASSWORD_HI_IDX:     pw_q[47:32] <= wr_mrg[15:0];
                default: begin
                    if (idx_w[9:4] == PATTERN_BASE_IDX[9:4]) begin
                        pat_q[{idx_w[3:0], 5'h00} +: 32] <= wr_mrg;
                    end
                end
            endcase
        end
    end

    // Read mux; unmapped reads return zero
    always_comb begin
        rd_d = 32'h00000000;
        case (idx_w)
            WAKE_CONFIG_REG_IDX: rd_d = {25'h0, cfg_q};
            WAKE_STATUS_REG_IDX: rd_d = {29'h0, sts_q};
            WAKE_MASK_IDX:       rd_d = {29'h0, mask_q};
            NODE_ADDR_LO_IDX:    rd_d = node_q[31:0];
            NODE_ADDR_HI_IDX:    rd_d = {16'h0, node_q[47:32]};
            PASSWORD_LO_IDX:     rd_d = pw_q[31:0];
            PASSWORD_HI_IDX:     rd_d = {16'h0, pw_q[47:32]};
            default: begin
                if (idx_w[9:4] == PATTERN_BASE_IDX[9:4]) begin
                    rd_d = pat_q[{idx_w[3:0], 5'h00} +: 32];
                end
            end
        endcase
    end

    // One wait state keeps the read data registered
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h00000000;
        end else begin
            o_wb_ack <= i_wb_cyc && i_wb_stb && !o_wb_ack;
            o_wb_dat <= rd_d;
        end
    end

    // Wake indications follow status by one cycle
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_irq      <= 1'b0;
            o_wake_pin <= 1'b0;
        end else begin
            o_irq      <= cfg_q[CFG_IRQ_EN] && |(sts_q & mask_q);
            o_wake_pin <= cfg_q[CFG_PIN_EN] &&
                          |sts_q[STS_PAT:STS_MAGIC];
        end
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_srst);

    chk_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack longer than one cycle");
    chk_crc_gate: assert property (magic_ev |-> crc_ok && !err_q)
        else $error("wake taken with bad crc");
    chk_irq_follow: assert property (
        cfg_q[CFG_IRQ_EN] && magic_ev && mask_q[STS_MAGIC]
        |=> ##1 o_irq)
        else $error("irq missing after wake");
    chk_pin_follow: assert property (
        cfg_q[CFG_PIN_EN] && pat_ev |=> ##1 o_wake_pin)
        else $error("pin missing after wake");
    chk_sync_run: assert property (
        st_q == ST_SYNC ##1 st_q == ST_REP |-> $past(ff_q) == SYNC_LEN)
        else $error("copies entered without sync run");
    chk_rep_done: assert property (
        byte_stb && st_q == ST_REP && rep_q == REP_END &&
        idx_q == ADDR_END && b == pick(node_q, idx_q) &&
        !cfg_q[CFG_PW_EN] |=> st_q == ST_HIT)
        else $error("sixteenth copy not accepted");
    chk_pw_break: assert property (
        byte_stb && st_q == ST_PW && b != pick(pw_q, idx_q)
        |=> st_q == ST_SYNC)
        else $error("password mismatch not rejected");
    chk_restart_ff: assert property (
        byte_stb && st_q == ST_REP && b != pick(node_q, idx_q) &&
        b == ALL_ONES |=> st_q == ST_SYNC && ff_q == 3'h1)
        else $error("restart lost current byte");
    chk_bcast_gate: assert property (
        magic_ev && !ucast_q |-> cfg_q[CFG_BCAST_EN])
        else $error("broadcast wake while disabled");
    chk_addr_gate: assert property (pat_ev |-> sa_ok_q)
        else $error("wake without valid source");
endmodule

// File: common/wake_pkg.sv
/*
 Constants, register indices and carrier types for the wake frame
 detector. Assumes a byte-wide receive stream and a 32-bit Wishbone bus.
*/
package wake_pkg;
    // Register indices; byte address is four times the index
    localparam logic [9:0] WAKE_CONFIG_REG_IDX = 10'h134;
    localparam logic [9:0] WAKE_STATUS_REG_IDX = 10'h135;
    localparam logic [9:0] NODE_ADDR_LO_IDX    = 10'h136;
    localparam logic [9:0] NODE_ADDR_HI_IDX    = 10'h137;
    localparam logic [9:0] PASSWORD_LO_IDX     = 10'h138;
    localparam logic [9:0] PASSWORD_HI_IDX     = 10'h139;
    localparam logic [9:0] WAKE_MASK_IDX       = 10'h13A;
    localparam logic [9:0] PATTERN_BASE_IDX    = 10'h140;
    localparam int         PATTERN_WORDS       = 16;
    // Configuration bit positions
    localparam int CFG_MAGIC_EN = 0;
    localparam int CFG_PAT_EN   = 1;
    localparam int CFG_BCAST_EN = 2;
    localparam int CFG_UCAST_EN = 3;
    localparam int CFG_PW_EN    = 4;
    localparam int CFG_IRQ_EN   = 5;
    localparam int CFG_PIN_EN   = 6;
    localparam int CFG_W        = 7;
    // Status and mask bit positions
    localparam int STS_MAGIC = 0;
    localparam int STS_PAT   = 1;
    localparam int STS_CRC   = 2;
    localparam int STS_W     = 3;
    // Reset values
    localparam logic [CFG_W-1:0] CFG_RST  = 7'h00;
    localparam logic [STS_W-1:0] MASK_RST = 3'h0;
    // Frame layout and sequence lengths
    localparam logic [6:0] DA_LEN   = 7'h06;
    localparam logic [6:0] PAY_POS  = 7'h0C;
    localparam logic [6:0] PAT_LEN  = 7'h40;
    localparam logic [6:0] POS_MAX  = 7'h7F;
    localparam logic [2:0] SYNC_LEN = 3'h6;
    localparam logic [2:0] ADDR_END = 3'h5;
    localparam logic [3:0] REP_END  = 4'hF;
    localparam logic [7:0] ALL_ONES = 8'hFF;
    localparam logic [31:0] CRC_INIT    = 32'hFFFFFFFF;
    localparam logic [31:0] CRC_RESIDUE = 32'hDEBB20E3;
    localparam logic [31:0] CRC_POLY    = 32'hEDB88320;

    // One received byte; stb marks a byte at any line speed
    typedef struct packed {
        logic       dv;
        logic       stb;
        logic       er;
        logic [7:0] data;
    } rx_byte_type;

    typedef enum logic [3:0] {
        ST_SYNC = 4'h1,
        ST_REP  = 4'h2,
        ST_PW   = 4'h4,
        ST_HIT  = 4'h8
    } scan_state_type;
endpackage

// File: rtl/wake_crc_check.sv
/*
 Running CRC-32 over a received frame including its check field.
 Assumes i_start stays high between frames and low while one is received.
*/
`timescale 1ns/1ps
module wake_crc_check
    import wake_pkg::*;
(
    // Clock and reset
    input  wire logic       i_clk_sys,
    input  wire logic       i_srst,
    // Byte stream
    input  wire logic       i_start,
    input  wire logic       i_stb,
    input  wire logic [7:0] i_data,
    // Result
    output logic            o_good
);
    logic [31:0] crc_q;

    function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                             input logic [7:0]  d);
        logic [31:0] r;
        r = c ^ {24'h000000, d};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    always_ff @(posedge i_clk_sys) begin
        if (i_srst || i_start) begin
            crc_q <= CRC_INIT;
        end else if (i_stb) begin
            crc_q <= crc_byte(crc_q, i_data);
        end
    end

    // Residue check covers data plus check field in one pass
    assign o_good = (crc_q == CRC_RESIDUE);
endmodule

// File: rtl/wake_pattern_match.sv
/*
 Compares the first 64 bytes of a frame with a programmed pattern.
 Assumes i_pos counts the bytes of the frame from zero.
*/
`timescale 1ns/1ps
module wake_pattern_match
    import wake_pkg::*;
(
    // Clock and reset
    input  wire logic         i_clk_sys,
    input  wire logic         i_srst,
    // Byte stream
    input  wire logic         i_start,
    input  wire logic         i_stb,
    input  wire logic [6:0]   i_pos,
    input  wire logic [7:0]   i_data,
    // Pattern and result
    input  wire logic [511:0] i_pattern,
    output logic              o_match
);
    logic ok_q;
    logic seen_q;

    always_ff @(posedge i_clk_sys) begin
        if (i_srst || i_start) begin
            ok_q   <= 1'b1;
            seen_q <= 1'b0;
        end else if (i_stb && i_pos < PAT_LEN) begin
            if (i_data != i_pattern[{i_pos[5:0], 3'b000} +: 8]) begin
                ok_q <= 1'b0;
            end
            if (i_pos == PAT_LEN - 7'h01) begin
                seen_q <= 1'b1;
            end
        end
    end

    // Short frames never match
    assign o_match = ok_q && seen_q;
endmodule

// File: tb/wake_line_model.sv
/*
 Line-side byte source feeding the wake detector with one frame at a time.
 Assumes the bench loads mem and i_len before pulsing i_go while idle.
*/
`timescale 1ns/1ps
module wake_line_model
    import wake_pkg::*;
(
    // Clock and reset
    input  wire logic       i_clk_sys,
    input  wire logic       i_srst,
    // Frame request
    input  wire logic       i_go,
    input  wire logic [8:0] i_len,
    input  wire logic [5:0] i_stride,
    // Byte stream out
    output rx_byte_type     o_rx,
    output logic            o_busy
);
    logic [7:0] mem [0:511];
    logic [8:0] idx_q;
    logic [5:0] cnt_q;

    always_ff @(posedge i_clk_sys) begin
        o_rx.er  <= 1'b0;
        o_rx.stb <= 1'b0;
        // Data inverts every cycle between strobes instead of holding the last byte
        o_rx.data <= ~o_rx.data;
        if (i_srst) begin
            o_busy    <= 1'b0;
            o_rx.dv   <= 1'b0;
            o_rx.data <= 8'h00;
        end else if (!o_busy) begin
            o_rx.dv <= 1'b0;
            if (i_go) begin
                o_busy <= 1'b1;
                idx_q  <= 9'h000;
                cnt_q  <= 6'h00;
            end
        end else if (idx_q == i_len) begin
            o_busy  <= 1'b0;
            o_rx.dv <= 1'b0;
        end else begin
            o_rx.dv <= 1'b1;
            cnt_q   <= (cnt_q == i_stride - 6'h01) ? 6'h00 : cnt_q + 6'h01;
            if (cnt_q == 6'h00) begin
                o_rx.stb  <= 1'b1;
                o_rx.data <= mem[idx_q];
                idx_q     <= idx_q + 9'h001;
            end
        end
    end
endmodule

// File: tb/wake_frame_detector_test.sv
/*
 Self-checking bench for the wake frame detector over Wishbone.
 Assumes the line model in wake_line_model and the package constants.
*/
`timescale 1ns/1ps
module wake_frame_detector_test;
    import wake_pkg::*;
    localparam logic [7:0] NODE [6] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55,
                                        8'h66};
    localparam logic [7:0] PWB [6] = '{8'h2A, 8'h2B, 8'h2C, 8'h2D, 8'h2E,
                                       8'h2F};
    logic        i_clk_sys;
    logic        i_srst;
    logic        cyc;
    logic        we;
    logic        go;
    logic        ack;
    logic        irq;
    logic        pin;
    logic        busy;
    logic [11:0] adr;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic [31:0] q;
    logic [8:0]  len;
    logic [5:0]  stride;
    logic [7:0]  fr [0:511];
    rx_byte_type rx;
    int          nb;
    int          err_count = 0;
    int          tests_run = 0;
    int          cycles = 0;

    wake_frame_detector dut (.i_clk_sys(i_clk_sys), .i_srst(i_srst),
        .i_rx(rx), .i_wb_cyc(cyc), .i_wb_stb(cyc), .i_wb_we(we),
        .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat), .o_wb_ack(ack),
        .o_wb_dat(rdat), .o_irq(irq), .o_wake_pin(pin));
    wake_line_model src (.i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_go(go),
        .i_len(len), .i_stride(stride), .o_rx(rx), .o_busy(busy));

    initial begin
        i_clk_sys = 1'b0;
        forever #12.5 i_clk_sys = ~i_clk_sys;
    end

    // Longest frame at the slowest stride stays far below this
    always @(posedge i_clk_sys) begin
        cycles++;
        if (cycles == 60000) begin
            err_count++;
            test_done;
        end
    end

    task test_done;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task wb(input logic w, input logic [9:0] idx, input logic [31:0] d);
        int n;
        @(posedge i_clk_sys);
        cyc  <= 1'b1;
        we   <= w;
        adr  <= {idx, 2'b00};
        wdat <= d;
        n = 0;
        do begin
            @(posedge i_clk_sys);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat;
        if (ack !== 1'b1)
            err_count++;
        cyc <= 1'b0;
        we  <= 1'b0;
    endtask

    task put(input logic [7:0] b);
        fr[nb] = b;
        nb++;
    endtask

    // Own CRC-32, reflected, so the bench does not lean on the design
    function automatic logic [31:0] crc(input int n);
        logic [31:0] c;
        c = 32'hFFFFFFFF;
        for (int i = 0; i < n; i++) begin
            c ^= {24'h000000, fr[i]};
            for (int b = 0; b < 8; b++)
                c = c[0] ? (c >> 1) ^ 32'hEDB88320 : c >> 1;
        end
        return ~c;
    endfunction

    task build(input int da, nff, ncp, input logic pw, bad, input int off);
        logic [31:0] f;
        nb = 0;
        for (int i = 0; i < 6; i++)
            put(da == 0 ? NODE[i] : (da == 1 ? 8'hFF : 8'hA5));
        for (int i = 0; i < 6; i++)
            put(8'h02);
        // Leading junk of short FF runs forces search restarts
        for (int i = 0; i < off; i++)
            put(i % 3 == 2 ? 8'h11 : 8'hFF);
        for (int i = 0; i < nff; i++)
            put(8'hFF);
        for (int i = 0; i < ncp * 6; i++)
            put(NODE[i % 6]);
        for (int i = 0; i < 6 && pw; i++)
            put(PWB[i]);
        put(8'h00);
        put(8'h00);
        f = crc(nb) ^ {31'h0, bad};
        for (int i = 0; i < 4; i++)
            put(f[8*i +: 8]);
        len = nb[8:0];
    endtask

    task send(input logic [5:0] s);
        int n;
        for (int i = 0; i < nb; i++)
            src.mem[i] = fr[i];
        stride <= s;
        @(posedge i_clk_sys);
        go <= 1'b1;
        @(posedge i_clk_sys);
        go <= 1'b0;
        n = 0;
        do begin
            @(posedge i_clk_sys);
            n++;
        end while (busy !== 1'b0 && n < 9000);
        repeat (2) @(posedge i_clk_sys);
    endtask

    task trial(input logic [6:0] cfg, input int da, nff, ncp,
               input logic pw, bad, input int off, input logic [5:0] s,
               input logic [2:0] e, input logic ei, ep);
        wb(1'b1, WAKE_CONFIG_REG_IDX, {25'h0, cfg});
        build(da, nff, ncp, pw, bad, off);
        send(s);
        chk("irq", {31'h0, ei}, {31'h0, irq});
        chk("pin", {31'h0, ep}, {31'h0, pin});
        wb(1'b0, WAKE_STATUS_REG_IDX, 32'h0);
        chk("status", {29'h0, e}, q);
        wb(1'b1, WAKE_STATUS_REG_IDX, 32'h7);
        wb(1'b0, WAKE_STATUS_REG_IDX, 32'h0);
        chk("cleared", 32'h0, q);
        chk("irq off", 32'h0, {31'h0, irq});
    endtask

    initial begin
        cyc = 1'b0;
        we = 1'b0;
        adr = 12'h000;
        wdat = 32'h0;
        go = 1'b0;
        len = 9'h000;
        stride = 6'h01;
        i_srst = 1'b1;
        repeat (6) @(posedge i_clk_sys);
        i_srst <= 1'b0;
        wb(1'b0, WAKE_CONFIG_REG_IDX, 32'h0);
        chk("config reset", 32'h0, q);
        wb(1'b0, WAKE_STATUS_REG_IDX, 32'h0);
        chk("status reset", 32'h0, q);
        wb(1'b0, WAKE_MASK_IDX, 32'h0);
        chk("mask reset", 32'h0, q);
        wb(1'b0, 10'h100, 32'h0);
        chk("unmapped", 32'h0, q);
        wb(1'b1, NODE_ADDR_LO_IDX, 32'h44332211);
        wb(1'b1, NODE_ADDR_HI_IDX, 32'h00006655);
        wb(1'b1, PASSWORD_LO_IDX, 32'h2D2C2B2A);
        wb(1'b1, PASSWORD_HI_IDX, 32'h00002F2E);
        wb(1'b1, WAKE_MASK_IDX, 32'h3);
        wb(1'b1, WAKE_CONFIG_REG_IDX, 32'h6D);
        wb(1'b0, WAKE_CONFIG_REG_IDX, 32'h0);
        chk("config", 32'h6D, q);
        trial(7'h6D, 0, 6, 16, 0, 0, 0, 1, 3'h1, 1, 1);
        trial(7'h6D, 0, 6, 16, 0, 0, 0, 4, 3'h1, 1, 1);
        trial(7'h6D, 0, 6, 16, 0, 0, 0, 32, 3'h1, 1, 1);
        trial(7'h6D, 0, 6, 16, 0, 0, 5, 1, 3'h1, 1, 1);
        trial(7'h6D, 0, 6, 16, 0, 1, 0, 1, 3'h4, 0, 0);
        trial(7'h6D, 2, 6, 16, 0, 0, 0, 1, 3'h0, 0, 0);
        trial(7'h6D, 1, 6, 16, 0, 0, 0, 1, 3'h1, 1, 1);
        trial(7'h69, 1, 6, 16, 0, 0, 0, 1, 3'h0, 0, 0);
        trial(7'h65, 0, 6, 16, 0, 0, 0, 1, 3'h0, 0, 0);
        trial(7'h6D, 0, 5, 16, 0, 0, 0, 1, 3'h0, 0, 0);
        trial(7'h6D, 0, 6, 15, 0, 0, 0, 1, 3'h0, 0, 0);
        trial(7'h7D, 0, 6, 16, 0, 0, 0, 1, 3'h0, 0, 0);
        trial(7'h7D, 0, 6, 16, 1, 0, 0, 1, 3'h1, 1, 1);
        trial(7'h4D, 0, 6, 16, 0, 0, 0, 1, 3'h1, 0, 1);
        trial(7'h2D, 0, 6, 16, 0, 0, 0, 1, 3'h1, 1, 0);
        build(0, 6, 16, 0, 0, 0);
        for (int w = 0; w < 16; w++)
            wb(1'b1, PATTERN_BASE_IDX + 10'(w),
               {fr[4*w+3], fr[4*w+2], fr[4*w+1], fr[4*w]});
        trial(7'h6E, 0, 6, 16, 0, 0, 0, 1, 3'h2, 1, 1);
        test_done;
    end
endmodule
